// ==== design/rhp_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module rhp_port #(
  parameter int HOLD_CYCLES = rhp_pkg::PF_HOLD_CYCLES,
  parameter int SQW_HALF    = rhp_pkg::SQW_HALF_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire rhp_pkg::rhp_host_t host,
  input  wire logic               supply_ok,
  input  wire logic               tod_alarm,
  input  wire logic               wd_alarm,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [7:0]              host_data_out,
  output logic                    host_data_oe,
  output logic                    ram_select_n,
  output logic                    ram_read_enable_n,
  output logic                    power_fail_n,
  output logic                    alarm_irq_primary_n,
  output logic                    alarm_irq_primary_oe,
  output logic                    alarm_irq_secondary,
  output logic                    alarm_irq_secondary_oe,
  output logic                    square_wave_out,
  output logic                    square_wave_oe,
  output logic                    irq
);
  import rhp_pkg::*;

  rhp_host_t         hs;
  logic              strobe_end;
  logic [7:0]        mem [ONCHIP_DEPTH];
  logic              wr_pend;
  logic [5:0]        wr_addr;
  logic [7:0]        wr_data;
  logic [22:0]       hold_cnt;
  logic              pf;
  logic              pf_q;
  logic [CTRL_W-1:0] ctrl;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   mask;
  logic [ST_W-1:0]   st_set;
  logic [ST_W-1:0]   st_clr;
  logic [4:0]        pulse_cnt;
  logic [14:0]       sqw_cnt;
  logic              pri_event;
  logic              sec_active;
  logic              onchip;
  logic              apb_wr;

  rhp_host_sync u_sync (
    .core_clk   (core_clk),
    .srst       (srst),
    .host       (host),
    .host_s     (hs),
    .strobe_end (strobe_end)
  );

  assign onchip = rhp_onchip(hs.addr);

  // Power fail: supply low, then held for the recovery time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_cnt <= 23'(HOLD_CYCLES);
    end else if (!supply_ok) begin
      hold_cnt <= 23'(HOLD_CYCLES);
    end else if (hold_cnt != 23'h000000) begin
      hold_cnt <= hold_cnt - 23'h000001;
    end
  end

  assign pf = !supply_ok || (hold_cnt != 23'h000000);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      power_fail_n <= 1'b0;
      pf_q         <= 1'b1;
    end else begin
      power_fail_n <= !pf;
      pf_q         <= pf;
    end
  end

  // External RAM strobes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ram_select_n      <= 1'b1;
      ram_read_enable_n <= 1'b1;
    end else begin
      ram_select_n      <= pf ? 1'b1 : hs.ce_n;
      ram_read_enable_n <= (!pf && !hs.ce_n && !onchip)
                           ? hs.oe_n : 1'b1;
    end
  end

  // Host write is latched while armed, committed at strobe end.
  // Chip-enable is ignored during power fail.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_addr <= 6'h00;
      wr_data <= 8'h00;
    end else begin
      wr_pend <= !pf && !hs.ce_n && !hs.we_n && onchip;
      if (!hs.ce_n && !hs.we_n) begin
        wr_addr <= hs.addr[5:0];
        wr_data <= hs.data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (wr_pend && strobe_end) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read drive; write-enable low drops the drive on the next clock
  always_ff @(posedge core_clk) begin
    if (srst) begin
      host_data_oe  <= 1'b0;
      host_data_out <= 8'h00;
    end else begin
      host_data_oe  <= !pf && !hs.ce_n && hs.we_n && !hs.oe_n
                       && onchip;
      host_data_out <= mem[hs.addr[5:0]];
    end
  end

  // APB slave: one access cycle, answer registered at setup
  assign apb_wr = psel && penable && pready && pwrite;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        if (paddr == OFF_CTRL) begin
          prdata <= {28'h0000000, ctrl};
        end else if (paddr == OFF_STATUS) begin
          prdata <= {29'h00000000, status};
        end else if (paddr == OFF_MASK) begin
          prdata <= {29'h00000000, mask};
        end else if (paddr == OFF_STATE) begin
          prdata <= {30'h00000000, supply_ok, pf};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= CTRL_RST;
      mask <= MASK_RST;
    end else if (apb_wr) begin
      if (paddr == OFF_CTRL) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end else if (paddr == OFF_MASK) begin
        mask <= pwdata[ST_W-1:0];
      end
    end
  end

  // Sticky status; a new event wins over a write-one clear.
  // Alarms are not gated by power state.
  assign st_set = {pf && !pf_q, wd_alarm, tod_alarm};
  assign st_clr = (apb_wr && paddr == OFF_STATUS) ? pwdata[ST_W-1:0]
                                                  : 3'h0;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      status <= ST_RST;
    end else begin
      status <= (status & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // Alarm routing
  assign pri_event  = ctrl[CTRL_PRI_WD] ? wd_alarm : tod_alarm;
  assign sec_active = ctrl[CTRL_PRI_WD] ? status[ST_TOD]
                                        : status[ST_WD];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pulse_cnt <= 5'h00;
    end else if (pri_event) begin
      pulse_cnt <= IRQ_PULSE_CYCLES;
    end else if (pulse_cnt != 5'h00) begin
      pulse_cnt <= pulse_cnt - 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      alarm_irq_primary_n    <= 1'b0;
      alarm_irq_primary_oe   <= 1'b0;
      alarm_irq_secondary    <= 1'b0;
      alarm_irq_secondary_oe <= 1'b0;
    end else begin
      alarm_irq_primary_n  <= 1'b0;
      alarm_irq_primary_oe <= ctrl[CTRL_PRI_LEVEL]
        ? (ctrl[CTRL_PRI_WD] ? status[ST_WD] : status[ST_TOD])
        : (pulse_cnt != 5'h00);
      alarm_irq_secondary    <= sec_active ~^ ctrl[CTRL_SEC_HIGH];
      // Open drain: pull low only
      alarm_irq_secondary_oe <= !(sec_active ~^ ctrl[CTRL_SEC_HIGH]);
    end
  end

  // Square wave, runs from the system clock divider
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sqw_cnt         <= 15'h0000;
      square_wave_out <= 1'b0;
      square_wave_oe  <= 1'b0;
    end else begin
      square_wave_oe <= ctrl[CTRL_SQW_EN];
      if (sqw_cnt == 15'(SQW_HALF - 1)) begin
        sqw_cnt         <= 15'h0000;
        square_wave_out <= !square_wave_out;
      end else begin
        sqw_cnt <= sqw_cnt + 15'h0001;
      end
    end
  end

  // Checks
  ram_sel_block_a: assert property (@(posedge core_clk)
    disable iff (srst) pf |=> ram_select_n)
    else $error("ram select passed during power fail");
  ram_sel_pass_a: assert property (@(posedge core_clk)
    disable iff (srst) !pf |=> ram_select_n == $past(hs.ce_n))
    else $error("ram select not following chip enable");
  onchip_oer_a: assert property (@(posedge core_clk)
    disable iff (srst) onchip |=> ram_read_enable_n)
    else $error("ram read enabled for on-chip address");
  ext_oer_a: assert property (@(posedge core_clk)
    disable iff (srst) (!pf && !hs.ce_n && !onchip && !hs.oe_n)
    |=> !ram_read_enable_n)
    else $error("ram read enable not forwarded");
  oer_pf_a: assert property (@(posedge core_clk)
    disable iff (srst) pf |=> ram_read_enable_n)
    else $error("ram read enabled during power fail");
  read_drive_a: assert property (@(posedge core_clk)
    disable iff (srst)
    host_data_oe |-> $past(!hs.oe_n && hs.we_n && !hs.ce_n))
    else $error("data driven outside a read");
  we_release_a: assert property (@(posedge core_clk)
    disable iff (srst) !hs.we_n |=> !host_data_oe)
    else $error("data bus kept during write strobe");
  write_commit_a: assert property (@(posedge core_clk)
    disable iff (srst)
    (wr_pend && strobe_end) |=> mem[$past(wr_addr)] == $past(wr_data))
    else $error("register write lost");
  pf_write_a: assert property (@(posedge core_clk)
    disable iff (srst) pf |=> !wr_pend)
    else $error("register write armed during power fail");
  recover_hold_a: assert property (@(posedge core_clk)
    disable iff (srst) $rose(supply_ok) |=> !power_fail_n [*8])
    else $error("power fail released too early");
  pf_out_a: assert property (@(posedge core_clk)
    disable iff (srst) !supply_ok |=> ##1 !power_fail_n)
    else $error("power fail output not asserted");
  pulse_len_a: assert property (@(posedge core_clk)
    disable iff (srst) (pri_event && !ctrl[CTRL_PRI_LEVEL])
    |=> ##[1:2] alarm_irq_primary_oe [*8])
    else $error("primary pulse too short");
  sqw_float_a: assert property (@(posedge core_clk)
    disable iff (srst) !ctrl[CTRL_SQW_EN] |=> !square_wave_oe)
    else $error("square wave driven while disabled");
  sqw_drive_a: assert property (@(posedge core_clk)
    disable iff (srst) ctrl[CTRL_SQW_EN] |=> square_wave_oe)
    else $error("square wave not driven while enabled");
  sec_pol_a: assert property (@(posedge core_clk)
    disable iff (srst) (sec_active && ctrl[CTRL_SEC_HIGH])
    |=> alarm_irq_secondary)
    else $error("secondary polarity wrong");
  sec_low_a: assert property (@(posedge core_clk)
    disable iff (srst) (sec_active && !ctrl[CTRL_SEC_HIGH])
    |=> !alarm_irq_secondary)
    else $error("secondary low polarity wrong");

  cov_ext_read: cover property (@(posedge core_clk) !ram_read_enable_n);
  cov_pf_enter: cover property (@(posedge core_clk) $fell(power_fail_n));
  cov_reg_write: cover property (@(posedge core_clk) wr_pend && strobe_end);
  cov_recover: cover property (@(posedge core_clk) $rose(power_fail_n));
  cov_irq: cover property (@(posedge core_clk) irq);
endmodule : rhp_port
`default_nettype wire

// ==== design/rhp_pkg.sv ====
// How it works
// - An on-chip address (0x00000 to 0x0003F) selects an internal byte and keeps ram_read_enable_n high.
// - An address above the on-chip range forwards output-enable to ram_read_enable_n.
// - An on-chip write stores the data bus when write-enable rises while chip-enable is low.
// - An on-chip read drives the selected byte only while chip-enable and output-enable are low and write-enable is high.
// - ram_select_n follows chip-enable while power is good and stays high during power fail.
// - ram_read_enable_n follows output-enable only with good power, chip-enable low and an external address.
// - The primary interrupt carries either the time-of-day or the watchdog alarm, the secondary the other.
// - The primary interrupt signals as a pulse or as a held low level.
// - The secondary interrupt polarity is selectable.
// - Interrupts and timekeeping keep running whatever the supply level.
// - The square-wave pin drives 1024 Hz when enabled and floats when disabled.
// - During power fail chip-enable is ignored for internal access and power_fail_n is low.
// - After the supply recovers, ram_select_n and power_fail_n stay blocked for 150 ms more.
// - A falling write-enable releases a data bus that was being driven.
package rhp_pkg;
  localparam logic [16:0] ONCHIP_LAST = 17'h0003F;
  localparam int          ONCHIP_DEPTH = 64;
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_MASK     = 12'h008;
  localparam logic [11:0] OFF_STATE    = 12'h00C;
  // Control bits
  localparam int          CTRL_PRI_WD    = 0;
  localparam int          CTRL_PRI_LEVEL = 1;
  localparam int          CTRL_SEC_HIGH  = 2;
  localparam int          CTRL_SQW_EN    = 3;
  localparam int          CTRL_W         = 4;
  localparam logic [3:0]  CTRL_RST       = 4'h0;
  // Status and mask bits
  localparam int          ST_TOD   = 0;
  localparam int          ST_WD    = 1;
  localparam int          ST_PF    = 2;
  localparam int          ST_W     = 3;
  localparam logic [2:0]  ST_RST   = 3'h0;
  localparam logic [2:0]  MASK_RST = 3'h0;
  // Timing
  localparam longint      CLK_HZ     = 40_000_000;
  localparam longint      PF_HOLD_MS = 150;
  localparam int          PF_HOLD_CYCLES =
    int'((CLK_HZ * PF_HOLD_MS + 999) / 1000);
  localparam longint      SQW_HZ = 1024;
  localparam int          SQW_HALF_CYCLES = int'(CLK_HZ / (2 * SQW_HZ));
  localparam logic [4:0]  IRQ_PULSE_CYCLES = 5'h10;

  typedef struct packed {
    logic [16:0] addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [7:0]  data;
  } rhp_host_t;

  function automatic logic rhp_onchip(input logic [16:0] a);
    return a <= ONCHIP_LAST;
  endfunction : rhp_onchip
endpackage : rhp_pkg

// ==== design/rhp_host_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rhp_host_sync (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire rhp_pkg::rhp_host_t host,
  output rhp_pkg::rhp_host_t     host_s,
  output logic                   strobe_end
);
  import rhp_pkg::*;

  rhp_host_t meta;
  logic      ce_q;
  logic      we_q;

  // Idle value keeps all strobes inactive out of reset
  localparam rhp_host_t IDLE = '{addr: 17'h00000, ce_n: 1'b1, oe_n: 1'b1,
                                 we_n: 1'b1, data: 8'h00};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta   <= IDLE;
      host_s <= IDLE;
    end else begin
      meta   <= host;
      host_s <= meta;
    end
  end

  // Edge detect on the second stage only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ce_q <= 1'b1;
      we_q <= 1'b1;
    end else begin
      ce_q <= host_s.ce_n;
      we_q <= host_s.we_n;
    end
  end

  // Write ends at the earlier rise of chip-enable or write-enable
  assign strobe_end = (!ce_q && !we_q) && (host_s.ce_n || host_s.we_n);
endmodule : rhp_host_sync
`default_nettype wire

// ==== dv/rhp_sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rhp_sram_model (
  input  wire logic       core_clk,
  input  wire logic       ram_select_n,
  input  wire logic       ram_read_enable_n,
  input  wire logic       we_n,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] data_in,
  output logic [7:0]      data_out,
  output logic            drive
);
  // 128 words: upper bits alias; on-chip bytes and external bytes at 0x40 to 0x7F stay apart
  logic [7:0] mem [128];
  logic       we_q;
  always @(posedge core_clk) begin
    we_q <= we_n;
    if (!ram_select_n && we_n && !we_q) begin
      mem[addr] <= data_in;
    end
  end
  // Drives only while the controller forwards both strobes
  assign drive    = !ram_select_n && !ram_read_enable_n;
  assign data_out = mem[addr];
endmodule : rhp_sram_model
`default_nettype wire

// ==== dv/rhp_port_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtc_host_port_sram_gating_test;
  import rhp_pkg::*;
  localparam int HOLD = 32;
  localparam int HALF = 8;
  logic        core_clk = 0, srst = 1, supply_ok = 1;
  logic        tod_alarm = 0, wd_alarm = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [16:0] h_addr = '0;
  logic        h_ce_n = 1, h_oe_n = 1, h_we_n = 1, tb_drv = 0;
  logic [7:0]  tb_d = '0, noise = 8'h5A, bus, ram_q, d1, d2, host_data_out;
  logic        pready, pslverr, host_data_oe, ram_select_n, ram_drv;
  logic        ram_read_enable_n, power_fail_n, alarm_irq_primary_n;
  logic        alarm_irq_primary_oe, alarm_irq_secondary, irq;
  logic        alarm_irq_secondary_oe, square_wave_out, square_wave_oe, sq;
  logic [32:0] exp_q [$];
  logic [32:0] e;
  logic [5:0]  a;
  int          bad_count = 0, comparisons = 0, n;
  rhp_host_t   host;
  // Released bus shows a changing pattern, never a stale byte
  assign bus  = tb_drv ? tb_d : host_data_oe ? host_data_out :
                ram_drv ? ram_q : noise;
  assign host = {h_addr, h_ce_n, h_oe_n, h_we_n, bus};
  initial forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) noise <= noise + 8'h3B;

  rhp_port #(.HOLD_CYCLES(HOLD), .SQW_HALF(HALF)) dut (
    .core_clk, .srst, .host, .supply_ok, .tod_alarm, .wd_alarm,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .host_data_out, .host_data_oe, .ram_select_n, .ram_read_enable_n,
    .power_fail_n, .alarm_irq_primary_n, .alarm_irq_primary_oe,
    .alarm_irq_secondary, .alarm_irq_secondary_oe, .square_wave_out,
    .square_wave_oe, .irq);
  rhp_sram_model ram (.core_clk, .ram_select_n, .ram_read_enable_n,
    .we_n(h_we_n), .addr(h_addr[6:0]), .data_in(bus), .data_out(ram_q),
    .drive(ram_drv));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [32:0] s,
                     input logic [32:0] x);
    comparisons++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d, input logic [32:0] x);
    int k;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
    if (!w) exp_q.push_back(x);
    cyc(1);
    penable <= 1;
    k = 0;
    do begin cyc(1); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin bad_count++; give_verdict(); end
    psel <= 0; penable <= 0;
    cyc(1);
  endtask : apb
  task automatic hend;
    h_ce_n <= 1; h_oe_n <= 1; h_we_n <= 1; tb_drv <= 0;
    cyc(5);
  endtask : hend
  task automatic hw(input logic [16:0] ad, input logic [7:0] d);
    // Output-enable stays high, chip-enable low over the whole cycle
    h_addr <= ad; tb_d <= d; tb_drv <= 1; h_ce_n <= 0; h_we_n <= 0;
    cyc(6);
    h_we_n <= 1;
    cyc(1);
    hend();
  endtask : hw
  task automatic hr(input logic [16:0] ad);
    h_addr <= ad; h_ce_n <= 0; h_oe_n <= 0;
    cyc(5);
  endtask : hr

  always @(posedge core_clk) begin
    if ((psel & penable & pready & ~pwrite) === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("apb_read", {pslverr, prdata}, e);
    end
  end
  initial begin cyc(20000); bad_count++; give_verdict(); end

  initial begin
    void'($urandom(21));
    cyc(3);
    srst <= 0;
    cyc(1);
    chk("sel_rst", ram_select_n, 1);
    chk("oer_rst", ram_read_enable_n, 1);
    chk("sqw_oe_rst", square_wave_oe, 0);
    chk("irq_rst", irq, 0);
    n = 0;
    while (power_fail_n !== 1'b1 && n < 100) begin cyc(1); n++; end
    chk("pf_hold_len", n >= HOLD - 1 && n <= HOLD + 4, 1);
    apb(0, OFF_CTRL, 0, {1'b0, 32'h0});
    apb(0, OFF_MASK, 0, {1'b0, 32'h0});
    apb(0, OFF_STATUS, 0, {1'b0, 32'h0});
    apb(1, 12'h010, 32'hFF, 0);
    apb(0, 12'h010, 0, {1'b1, 32'h0});
    apb(0, OFF_STATE, 0, {1'b0, 32'h2});
    a = 6'($urandom);
    d1 = 8'($urandom);
    d2 = ~d1;
    hw({11'h0, a}, d1);
    hw({11'h1, a}, d2);
    hr({11'h0, a});
    chk("rd_oe", host_data_oe, 1);
    chk("rd_data", host_data_out, d1);
    chk("oer_onchip", ram_read_enable_n, 1);
    chk("pri_value", alarm_irq_primary_n, 0);
    tb_drv <= 1; tb_d <= d1; h_we_n <= 0;
    cyc(5);
    chk("we_release", host_data_oe, 0);
    hend();
    hr({11'h1, a});
    chk("oer_ext", ram_read_enable_n, 0);
    chk("sel_ext", ram_select_n, 0);
    chk("ext_no_drive", host_data_oe, 0);
    chk("ext_data", bus, d2);
    supply_ok <= 0;
    cyc(5);
    chk("sel_pf", ram_select_n, 1);
    chk("oer_pf", ram_read_enable_n, 1);
    chk("pf_out", power_fail_n, 0);
    h_addr <= {11'h0, a}; wd_alarm <= 1;
    cyc(1);
    wd_alarm <= 0;
    cyc(5);
    chk("pf_no_read", host_data_oe, 0);
    supply_ok <= 1;
    cyc(HOLD - 8);
    chk("sel_hold", ram_select_n, 1);
    chk("pf_hold", power_fail_n, 0);
    cyc(16);
    chk("sel_back", ram_select_n, 0);
    chk("pf_back", power_fail_n, 1);
    chk("rd_back", host_data_oe, 1);
    hend();
    apb(0, OFF_STATUS, 0, {1'b0, 32'h6});
    apb(1, OFF_MASK, 32'h4, 0);
    cyc(2);
    chk("irq_on", irq, 1);
    apb(1, OFF_STATUS, 32'h4, 0);
    cyc(2);
    chk("irq_off", irq, 0);
    chk("sec_low", alarm_irq_secondary_oe, 1);
    tod_alarm <= 1;
    cyc(1);
    tod_alarm <= 0;
    cyc(4);
    chk("pri_pulse", alarm_irq_primary_oe, 1);
    cyc(18);
    chk("pri_pulse_end", alarm_irq_primary_oe, 0);
    apb(1, OFF_CTRL, 32'h6, 0);
    cyc(4);
    chk("sec_high", alarm_irq_secondary, 1);
    chk("pri_level", alarm_irq_primary_oe, 1);
    apb(1, OFF_STATUS, 32'h1, 0);
    cyc(4);
    chk("pri_level_clr", alarm_irq_primary_oe, 0);
    apb(1, OFF_CTRL, 32'h7, 0);
    cyc(4);
    chk("pri_wd", alarm_irq_primary_oe, 1);
    chk("sec_tod", alarm_irq_secondary, 0);
    apb(1, OFF_CTRL, 32'h8, 0);
    cyc(3);
    chk("sqw_oe", square_wave_oe, 1);
    for (int i = 0; i < 2; i++) begin
      sq = square_wave_out;
      n = 0;
      while (square_wave_out === sq && n < 40) begin cyc(1); n++; end
    end
    chk("sqw_half", n, HALF);
    apb(1, OFF_CTRL, 32'h0, 0);
    cyc(3);
    chk("sqw_off", square_wave_oe, 0);
    give_verdict();
  end
endmodule : rtc_host_port_sram_gating_test
`default_nettype wire
